// ### rtl/uart_port_pkg.sv
// Shared constants for the serial port and its far-end partner
package uart_port_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BAUD_MIN = 300;
  localparam int unsigned BAUD_MAX = 6000000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  // Cycles per bit: 25 MHz / 9600 rounded down
  localparam int unsigned DIV_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  // Shortest legal divider, at the highest rate
  localparam int unsigned DIV_MIN = 4;
  localparam int unsigned DIV_W = 17;
  localparam int unsigned DATA_BITS_DEFAULT = 8;
  // Parity selection codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  // Mode strap code for serial mode: select 2,1 low, 0 high
  localparam logic [2:0] MODE_SERIAL = 3'h1;
  localparam logic RESET_FLOW = 1'b1;
  localparam logic RESET_TWO_STOP = 1'b0;
  localparam logic RESET_SEVEN = 1'b0;
endpackage : uart_port_pkg

// ### rtl/uart_link_if.sv
// Serial link wires between the port and the far-end device
`timescale 1ns/1ps
interface uart_link_if;
  logic txd;
  logic rxd;
  logic rts_n;
  logic cts_n;
  logic tx_active;
  logic link_fault_n;
  modport port (output txd, input rxd, output rts_n, input cts_n,
                output tx_active, output link_fault_n);
  modport far (input txd, output rxd, input rts_n, output cts_n,
               input tx_active, input link_fault_n);
endinterface : uart_link_if

// ### rtl/uart_far_end.sv
// Far-end serial device: frames bytes to the port, gated by link state
`timescale 1ns/1ps
module uart_far_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link
  uart_link_if.far link,
  // Line settings
  input wire logic [16:0] bit_div,
  input wire logic seven_bits,
  input wire logic [1:0] parity_sel,
  input wire logic two_stop,
  // Byte to send
  input wire logic [7:0] send_data,
  input wire logic send_valid,
  output logic send_ready,
  // Flow control toward the port
  input wire logic hold_off
);
  typedef enum logic [1:0] {
    F_IDLE = 2'b00, F_SHIFT = 2'b01
  } far_state_type;
  far_state_type st_q, st_d;
  logic [11:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [16:0] tick_q, tick_d;
  logic rdy_q, rdy_d;
  logic cts_q, cts_d;
  logic line_q, line_d;
  logic par;
  assign link.rxd = line_q;
  assign link.cts_n = cts_q;
  assign send_ready = rdy_q;
  // Next-state: send only after enumeration and when port asks
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    tick_d = tick_q;
    line_d = line_q;
    rdy_d = 1'b0;
    cts_d = hold_off;
    par = seven_bits ? ^send_data[6:0] : ^send_data;
    if (parity_sel == uart_port_pkg::PAR_ODD) par = ~par;
    case (st_q)
      F_IDLE: begin
        line_d = 1'b1;
        // Wait for enumeration and the port's request to send
        if (send_valid && !link.link_fault_n && !link.rts_n) begin
          rdy_d = 1'b1;
          // Start, data LSB first, parity, stops
          sh_d = {2'b11, 10'h3FF};
          if (seven_bits) begin
            sh_d[7:0] = {send_data[6:0], 1'b0};
            sh_d[8] = (parity_sel == uart_port_pkg::PAR_NONE) ? 1'b1 : par;
          end else begin
            sh_d[8:0] = {send_data, 1'b0};
            sh_d[9] = (parity_sel == uart_port_pkg::PAR_NONE) ? 1'b1 : par;
          end
          cnt_d = 4'(1 + (seven_bits ? 7 : 8) + 1 + (two_stop ? 1 : 0)
                  + ((parity_sel == uart_port_pkg::PAR_NONE) ? 0 : 1));
          tick_d = bit_div;
          st_d = F_SHIFT;
        end
      end
      F_SHIFT: begin
        line_d = sh_q[0];
        if (tick_q <= 17'h00001) begin
          tick_d = bit_div;
          sh_d = {1'b1, sh_q[11:1]};
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1) st_d = F_IDLE;
        end else begin
          tick_d = tick_q - 17'h00001;
        end
      end
      default: st_d = F_IDLE;
    endcase
  end
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= F_IDLE;
      sh_q <= 12'hFFF;
      cnt_q <= 4'h0;
      tick_q <= 17'h00000;
      rdy_q <= 1'b0;
      cts_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      rdy_q <= rdy_d;
      cts_q <= cts_d;
      line_q <= line_d;
    end
  end
endmodule : uart_far_end

// ### rtl/uart_bridge_port.sv
// Serial port end of the bridge: transmitter, receiver, line settings
`timescale 1ns/1ps
// How it works
// - Start, 7/8 data, optional parity, 1-2 stops
// - Data bits go least significant first
// - Divider covers 300 baud to 6 Mbaud
// - Reset gives 9600 baud, RTS/CTS on
// - Reset format is 8 data, no parity, 1 stop
// - Host config command with a legal divider sets every line setting
// - Transmit-active high while a frame is sent
// - RTS and CTS are low-true
// - Fixed pins for data and handshake lines
// - Far device waits for enumeration before sending
// - Link-fault output idles high, low after enumeration
// - Port works only in serial mode
// - Serial mode strap is select pins 001
module uart_bridge_port #(
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Mode straps and enumeration state
  input wire logic mode_select_0,
  input wire logic mode_select_1,
  input wire logic mode_select_2,
  input wire logic enumerated,
  // Configuration command from the host side
  input wire logic cfg_valid,
  input wire logic [16:0] cfg_div,
  input wire logic cfg_flow,
  input wire logic cfg_seven,
  input wire logic [1:0] cfg_parity,
  input wire logic cfg_two_stop,
  // Transmit stream from the host side
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive stream to the host side
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_parity_err,
  output logic rx_frame_err,
  // Link
  uart_link_if.port link
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_BITS = 2'b01, S_DONE = 2'b10
  } ser_state_type;

  // Line settings
  logic [16:0] div_q, div_d;
  logic flow_q, flow_d, seven_q, seven_d, two_q, two_d;
  logic [1:0] par_q, par_d;
  logic serial_on;
  logic fault_q, fault_d;
  assign serial_on = ({mode_select_2, mode_select_1, mode_select_0}
                      == uart_port_pkg::MODE_SERIAL);

  // Settings: reset defaults, then host commands
  always_comb begin
    div_d = div_q;
    flow_d = flow_q;
    seven_d = seven_q;
    par_d = par_q;
    two_d = two_q;
    if (cfg_valid && cfg_div >= 17'(uart_port_pkg::DIV_MIN)) begin
      div_d = cfg_div;
      flow_d = cfg_flow;
      seven_d = cfg_seven;
      par_d = cfg_parity;
      two_d = cfg_two_stop;
    end
  end

  // Transmitter
  ser_state_type ts_q, ts_d;
  logic [11:0] tsh_q, tsh_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic [16:0] ttick_q, ttick_d;
  logic txd_q, txd_d, act_q, act_d, trdy_q, trdy_d;
  logic tpar;
  always_comb begin
    ts_d = ts_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    ttick_d = ttick_q;
    txd_d = 1'b1;
    act_d = 1'b0;
    trdy_d = 1'b0;
    tpar = seven_q ? ^tx_data[6:0] : ^tx_data;
    if (par_q == uart_port_pkg::PAR_ODD) tpar = ~tpar;
    case (ts_q)
      S_IDLE: begin
        // Start only in serial mode and, with flow control on, only when the far end clears us
        if (serial_on && tx_valid && !trdy_q
            && (!flow_q || !link.cts_n)) begin
          trdy_d = 1'b1;
          tsh_d = 12'hFFF;
          if (seven_q) begin
            tsh_d[7:0] = {tx_data[6:0], 1'b0};
            if (par_q != uart_port_pkg::PAR_NONE) tsh_d[8] = tpar;
          end else begin
            tsh_d[8:0] = {tx_data[7:0], 1'b0};
            if (par_q != uart_port_pkg::PAR_NONE) tsh_d[9] = tpar;
          end
          tcnt_d = 4'(1 + (seven_q ? 7 : 8) + (two_q ? 2 : 1)
                   + ((par_q == uart_port_pkg::PAR_NONE) ? 0 : 1));
          ttick_d = div_q;
          ts_d = S_BITS;
        end
      end
      S_BITS: begin
        txd_d = tsh_q[0];
        act_d = 1'b1;
        if (ttick_q <= 17'h00001) begin
          ttick_d = div_q;
          tsh_d = {1'b1, tsh_q[11:1]};
          tcnt_d = tcnt_q - 4'h1;
          if (tcnt_q == 4'h1) begin
            ts_d = S_IDLE;
            txd_d = 1'b1;
            act_d = 1'b0;
          end
        end else begin
          ttick_d = ttick_q - 17'h00001;
        end
      end
      default: ts_d = S_IDLE;
    endcase
  end

  // Receiver
  ser_state_type rs_q, rs_d;
  logic [9:0] rsh_q, rsh_d;
  logic [3:0] rcnt_q, rcnt_d;
  logic [16:0] rtick_q, rtick_d;
  logic rxd_prev_q, rxd_prev_d;
  logic [7:0] rbyte;
  logic rpar_bad, rfr_bad, rpush;
  logic [3:0] nbits;
  assign nbits = 4'((seven_q ? 7 : 8)
                 + ((par_q == uart_port_pkg::PAR_NONE) ? 0 : 1));
  always_comb begin
    rs_d = rs_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rtick_d = rtick_q;
    rxd_prev_d = link.rxd;
    rpush = 1'b0;
    rbyte = seven_q ? {1'b0, rsh_q[8:2]} : rsh_q[9:2];
    rpar_bad = (seven_q ? ^rsh_q[9:2] : ^rsh_q[9:1]) ^
               (par_q == uart_port_pkg::PAR_ODD);
    if (par_q == uart_port_pkg::PAR_NONE) begin
      rpar_bad = 1'b0;
      rbyte = seven_q ? {1'b0, rsh_q[9:3]} : rsh_q[9:2];
    end
    if (seven_q && par_q == uart_port_pkg::PAR_NONE)
      rbyte = {1'b0, rsh_q[9:3]};
    else if (!seven_q && par_q != uart_port_pkg::PAR_NONE)
      rbyte = rsh_q[8:1];
    else if (seven_q)
      rbyte = {1'b0, rsh_q[8:2]};
    rfr_bad = 1'b0;
    case (rs_q)
      S_IDLE: begin
        if (serial_on && rxd_prev_q && !link.rxd) begin
          rtick_d = {1'b0, div_q[16:1]};
          rcnt_d = 4'h0;
          rs_d = S_BITS;
        end
      end
      S_BITS: begin
        if (rtick_q <= 17'h00001) begin
          rtick_d = div_q;
          if (rcnt_q == 4'h0 && link.rxd) begin
            rs_d = S_IDLE; // False start
          end else if (rcnt_q == nbits + 4'h1) begin
            // Stop sample: every data and parity bit already shifted in
            rs_d = S_DONE;
          end else begin
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q != 4'h0) rsh_d = {link.rxd, rsh_q[9:1]};
          end
        end else begin
          rtick_d = rtick_q - 17'h00001;
        end
      end
      S_DONE: begin
        // Stop sample taken at bit centre on entry
        rfr_bad = !rxd_prev_q;
        rpush = 1'b1;
        rs_d = S_IDLE;
      end
      default: rs_d = S_IDLE;
    endcase
  end

  // Two-entry receive buffer, back-pressure via rts_n
  logic [DATA_W+1:0] buf_q [2];
  logic [DATA_W+1:0] buf_d [2];
  logic [1:0] fill_q, fill_d;
  logic rts_q, rts_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic rval_q, rval_d, rperr_q, rperr_d, rferr_q, rferr_d;
  always_comb begin
    buf_d = buf_q;
    fill_d = fill_q;
    if (rval_q && rx_ready) begin
      buf_d[0] = buf_q[1];
      fill_d = fill_q - 2'h1;
    end
    if (rpush && fill_d != 2'h2) begin
      buf_d[fill_d[0]] = {rfr_bad, rpar_bad, DATA_W'(rbyte)};
      fill_d = fill_d + 2'h1;
    end
    rval_d = (fill_d != 2'h0);
    rdat_d = buf_d[0][DATA_W-1:0];
    rperr_d = buf_d[0][DATA_W];
    rferr_d = buf_d[0][DATA_W+1];
    // Request to send only in serial mode: while the buffer is empty, or always with flow control off
    rts_d = !(serial_on && (!flow_q || fill_d == 2'h0));
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q <= 17'(uart_port_pkg::DIV_DEFAULT);
      flow_q <= uart_port_pkg::RESET_FLOW;
      seven_q <= uart_port_pkg::RESET_SEVEN;
      par_q <= uart_port_pkg::PAR_NONE;
      two_q <= uart_port_pkg::RESET_TWO_STOP;
      ts_q <= S_IDLE;
      tsh_q <= 12'hFFF;
      tcnt_q <= 4'h0;
      ttick_q <= 17'h00000;
      txd_q <= 1'b1;
      act_q <= 1'b0;
      trdy_q <= 1'b0;
      rs_q <= S_IDLE;
      rsh_q <= 10'h000;
      rcnt_q <= 4'h0;
      rtick_q <= 17'h00000;
      rxd_prev_q <= 1'b1;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      fill_q <= 2'h0;
      rts_q <= 1'b1;
      rdat_q <= '0;
      rval_q <= 1'b0;
      rperr_q <= 1'b0;
      rferr_q <= 1'b0;
      fault_q <= 1'b1;
    end else begin
      div_q <= div_d;
      flow_q <= flow_d;
      seven_q <= seven_d;
      par_q <= par_d;
      two_q <= two_d;
      ts_q <= ts_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      ttick_q <= ttick_d;
      txd_q <= txd_d;
      act_q <= act_d;
      trdy_q <= trdy_d;
      rs_q <= rs_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      rtick_q <= rtick_d;
      rxd_prev_q <= rxd_prev_d;
      buf_q <= buf_d;
      fill_q <= fill_d;
      rts_q <= rts_d;
      rdat_q <= rdat_d;
      rval_q <= rval_d;
      rperr_q <= rperr_d;
      rferr_q <= rferr_d;
      fault_q <= fault_d;
    end
  end

  // Link-fault flag: low once enumeration completes
  assign fault_d = !enumerated;

  // Outputs, all from flip-flops
  assign link.txd = txd_q;
  assign link.tx_active = act_q;
  assign link.rts_n = rts_q;
  assign link.link_fault_n = fault_q;
  assign tx_ready = trdy_q;
  assign rx_data = rdat_q;
  assign rx_valid = rval_q;
  assign rx_parity_err = rperr_q;
  assign rx_frame_err = rferr_q;
endmodule : uart_bridge_port

// ### verification/uart_port_chk.sv
// Link checker for the serial port facing its far-end partner
`timescale 1ns/1ps
module uart_port_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link wires
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic tx_active,
  input wire logic link_fault_n
);
  localparam int unsigned MIN_FRAME = 36;
  logic [31:0] act_cnt_q;
  logic [31:0] act_cnt_d;
  // Length of the frame now on the wire
  always_comb begin
    act_cnt_d = tx_active ? act_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk) begin
    act_cnt_q <= rst_n ? act_cnt_d : 32'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Frame opens: active rises together with a low start bit
  sequence frame_start;
    $rose(tx_active) ##0 !txd;
  endsequence
  chk_reset_state: assert property ($rose(rst_n) |->
    txd && !tx_active && rts_n && link_fault_n)
    else $error("link not idle after reset");
  chk_idle_high: assert property (!tx_active |-> txd)
    else $error("txd low outside a frame");
  chk_start_low: assert property ($rose(tx_active) |-> !txd)
    else $error("frame without start bit");
  // Acceptance edge lies two edges before the rise of transmit-active
  chk_cts_gate: assert property (frame_start |-> !$past(cts_n, 2))
    else $error("frame began with cts_n high");
  chk_stop_high: assert property ($fell(tx_active) |-> $past(txd))
    else $error("last stop bit low");
  chk_bit_hold: assert property (tx_active && $changed(txd) |=>
    $stable(txd) [*3])
    else $error("bit shorter than four cycles");
  chk_frame_len: assert property ($fell(tx_active) |->
    act_cnt_q >= MIN_FRAME)
    else $error("transmit active too short");
  chk_fault_hold: assert property (!link_fault_n |=> !link_fault_n)
    else $error("link fault returned high");
  chk_fault_gate: assert property (link_fault_n |-> rxd)
    else $error("far end sent before enumeration");
endmodule : uart_port_chk

// ### verification/usb_bridge_uart_port_tb_top.sv
// Bench joining the serial port to its far end, checking both ways
`timescale 1ns/1ps
module usb_bridge_uart_port_tb_top;
  logic core_clk, rst_n, enumerated, cfg_valid, cfg_flow, cfg_seven;
  logic mode_select_0, mode_select_1, mode_select_2, cfg_two_stop;
  logic [16:0] cfg_div, bit_div;
  logic [1:0] cfg_parity, parity_sel;
  logic [7:0] tx_data, rx_data, send_data;
  logic tx_valid, tx_ready, rx_valid, rx_ready, rx_parity_err, rx_frame_err;
  logic seven_bits, two_stop, send_valid, send_ready, hold_off;
  int n_mismatch, checks_done, div;
  uart_link_if link ();
  uart_bridge_port uart_bridge_port_i (.core_clk(core_clk), .rst_n(rst_n),
    .mode_select_0(mode_select_0), .mode_select_1(mode_select_1),
    .mode_select_2(mode_select_2), .enumerated(enumerated),
    .cfg_valid(cfg_valid), .cfg_div(cfg_div), .cfg_flow(cfg_flow),
    .cfg_seven(cfg_seven), .cfg_parity(cfg_parity),
    .cfg_two_stop(cfg_two_stop), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .link(link.port));
  uart_far_end uart_far_end_i (.core_clk(core_clk), .rst_n(rst_n),
    .link(link.far), .bit_div(bit_div), .seven_bits(seven_bits),
    .parity_sel(parity_sel), .two_stop(two_stop), .send_data(send_data),
    .send_valid(send_valid), .send_ready(send_ready), .hold_off(hold_off));
  uart_port_chk uart_port_chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .txd(link.txd), .rxd(link.rxd), .rts_n(link.rts_n), .cts_n(link.cts_n),
    .tx_active(link.tx_active), .link_fault_n(link.link_fault_n));
  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Bounded wait for a level, sampled just after each edge
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= lim) check("wait", s, v);
  endtask : wait_for
  // Line settings to both ends at once
  task automatic cfg(input int d, input logic fl, input logic sv,
                     input logic [1:0] p, input logic two);
    @(negedge core_clk);
    cfg_valid = 1'b1;
    cfg_div = 17'(d);
    cfg_flow = fl;
    cfg_seven = sv;
    cfg_parity = p;
    cfg_two_stop = two;
    bit_div = 17'(d);
    seven_bits = sv;
    parity_sel = p;
    two_stop = two;
    if (d >= uart_port_pkg::DIV_MIN) div = d;
    @(negedge core_clk);
    cfg_valid = 1'b0;
  endtask : cfg
  // Sends one byte from the port and samples its frame at bit centres
  task automatic tx_frame(input logic [7:0] d, input int nb,
                          input logic [1:0] p, input int st);
    logic [7:0] got;
    logic par;
    got = 8'h00;
    par = (p == uart_port_pkg::PAR_ODD);
    fork
      begin
        @(negedge core_clk);
        tx_data = d;
        tx_valid = 1'b1;
        wait_for(tx_ready, 1'b1, 99999);
        @(negedge core_clk);
        tx_valid = 1'b0;
      end
      begin
        wait_for(link.txd, 1'b0, 99999);
        repeat (div / 2) @(posedge core_clk);
        check("start", link.txd, 1'b0);
        check("active", link.tx_active, 1'b1);
        for (int i = 0; i < nb; i++) begin
          repeat (div) @(posedge core_clk);
          got[i] = link.txd;
          par ^= link.txd;
        end
        check("data", got, d & 8'((1 << nb) - 1));
        if (p != uart_port_pkg::PAR_NONE) begin
          repeat (div) @(posedge core_clk);
          check("parity", link.txd, par);
        end
        repeat (st) begin
          repeat (div) @(posedge core_clk);
          check("stop", link.txd, 1'b1);
        end
        repeat (div) @(posedge core_clk);
        check("active end", link.tx_active, 1'b0);
      end
    join
  endtask : tx_frame
  task automatic far_send(input logic [7:0] d);
    @(negedge core_clk);
    send_data = d;
    send_valid = 1'b1;
    wait_for(send_ready, 1'b1, 99999);
    @(negedge core_clk);
    send_valid = 1'b0;
  endtask : far_send
  task automatic rx_get(input logic [7:0] e, input logic [7:0] m,
                        input logic pe, input logic fe);
    wait_for(rx_valid, 1'b1, 99999);
    check("rx data", rx_data & m, e);
    check("parity err", rx_parity_err, pe);
    check("frame err", rx_frame_err, fe);
    @(negedge core_clk);
    rx_ready = 1'b1;
    @(negedge core_clk);
    rx_ready = 1'b0;
  endtask : rx_get
  // Cuts a hang short
  initial begin
    #4000000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_n, enumerated, cfg_valid, cfg_flow, cfg_seven, cfg_two_stop} = 0;
    {tx_valid, rx_ready, send_valid, hold_off, seven_bits, two_stop} = 0;
    {cfg_div, cfg_parity, tx_data, send_data, parity_sel} = 0;
    {mode_select_2, mode_select_1, mode_select_0} = 3'h1;
    bit_div = 17'(uart_port_pkg::DIV_DEFAULT);
    div = uart_port_pkg::DIV_DEFAULT;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    check("fault idle", link.link_fault_n, 1'b1);
    @(negedge core_clk);
    enumerated = 1'b1;
    wait_for(link.link_fault_n, 1'b0, 4);
    wait_for(link.rts_n, 1'b0, 4);
    tx_frame(8'hA5, 8, uart_port_pkg::PAR_NONE, 1);
    cfg(2, 1'b1, 1'b0, uart_port_pkg::PAR_NONE, 1'b0);
    tx_frame(8'h3C, 8, uart_port_pkg::PAR_NONE, 1);
    // Each data width, stop count and parity code, both directions
    for (int i = 0; i < 4; i++) begin
      cfg(4 + 4 * i, 1'b1, i[0], 2'(i % 3), i[1]);
      tx_frame(8'h96 ^ 8'(i), i[0] ? 7 : 8, 2'(i % 3), i[1] ? 2 : 1);
      far_send(8'hE9 ^ 8'(i));
      rx_get((8'hE9 ^ 8'(i)) & (i[0] ? 8'h7F : 8'hFF),
             i[0] ? 8'h7F : 8'hFF, 1'b0, 1'b0);
    end
    // Stall by clear-to-send, then by a foreign mode
    for (int j = 0; j < 2; j++) begin
      @(negedge core_clk);
      hold_off = (j == 0);
      mode_select_0 = (j == 0);
      fork
        tx_frame(8'h4D, 7, uart_port_pkg::PAR_NONE, 2);
        begin
          repeat (60) @(posedge core_clk);
          check("stalled", link.tx_active, 1'b0);
          @(negedge core_clk);
          hold_off = 1'b0;
          mode_select_0 = 1'b1;
        end
      join
    end
    // Parity mismatch, and request-to-send high while a byte waits
    cfg(8, 1'b1, 1'b0, uart_port_pkg::PAR_EVEN, 1'b0);
    parity_sel = uart_port_pkg::PAR_ODD;
    far_send(8'h33);
    wait_for(rx_valid, 1'b1, 9999);
    repeat (3) @(posedge core_clk);
    check("rts busy", link.rts_n, 1'b1);
    rx_get(8'h33, 8'hFF, 1'b1, 1'b0);
    // Stop position carries a low data bit
    cfg(8, 1'b1, 1'b1, uart_port_pkg::PAR_NONE, 1'b0);
    seven_bits = 1'b0;
    far_send(8'h35);
    rx_get(8'h35, 8'h7F, 1'b0, 1'b1);
    // Buffer of two fills, third byte is dropped
    cfg(8, 1'b0, 1'b0, uart_port_pkg::PAR_NONE, 1'b0);
    for (int k = 0; k < 3; k++) far_send(8'hB0 + 8'(k));
    repeat (120) @(posedge core_clk);
    rx_get(8'hB0, 8'hFF, 1'b0, 1'b0);
    rx_get(8'hB1, 8'hFF, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    check("dropped", rx_valid, 1'b0);
    finish_test();
  end
endmodule : usb_bridge_uart_port_tb_top
